/* rtl/frame_sched_pkg.sv */
// Purpose: Shared constants and types for the combined serial frame scheduler.
// Assumes: One core clock; baud clock sampled as a plain input.
// Notes:   Counts are in baud half-bit ticks unless named otherwise.
package frame_sched_pkg;
    localparam int          FRAME_BITS     = 16;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          FIFO_AW        = 3;
    // One frame is two ticks per bit, then the post-transfer delay phase
    localparam logic [5:0]  FRAME_TICKS    = 6'h20;
    localparam logic [5:0]  DT_TICKS       = 6'h03;
    localparam logic [7:0]  STREAM_PERIOD  = 8'h40;
    localparam int          HALT_WAIT_BAUD = 35;

    typedef enum logic [1:0] {
        MODE_COMBINED    = 2'h0,
        MODE_STREAM_ONLY = 2'h1,
        MODE_SPI_ONLY    = 2'h2
    } mode_t;

    // Gray along idle -> shift -> delay, halted off idle; delay -> idle flips both bits
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SHIFT  = 2'h1,
        ST_DELAY  = 2'h3,
        ST_HALTED = 2'h2
    } state_t;

    localparam logic [15:0] FRAME_RESET = 16'h0000;
endpackage : frame_sched_pkg

/* rtl/fifo_port_if.sv */
// Purpose: Carrier between the scheduler and its transmit FIFO memory.
// Assumes: Both ends on core_clk.
// Notes:   rd_valid lags a write by one cycle so rd_data is always current.
`timescale 1ns/10ps
`default_nettype none
interface fifo_port_if;
    logic        wr_en;
    logic [15:0] wr_data;
    logic        full;
    logic        rd_en;
    logic [15:0] rd_data;
    logic        rd_valid;

    modport owner (output wr_en, output wr_data, output rd_en,
                   input full, input rd_data, input rd_valid);
    modport store (input wr_en, input wr_data, input rd_en,
                   output full, output rd_data, output rd_valid);
endinterface : fifo_port_if
`default_nettype wire

/* rtl/push_fifo_mem.sv */
// Purpose: Transmit FIFO storage for host-pushed SPI frames.
// Assumes: Caller never pops while rd_valid is low.
// Notes:   Read data come from a register holding the current head.
`timescale 1ns/10ps
`default_nettype none
module push_fifo_mem (
    input  wire logic  core_clk,
    input  wire logic  reset,
    input  wire logic  ce,
    fifo_port_if.store fp
);
    typedef struct packed {
        logic [frame_sched_pkg::FIFO_DEPTH-1:0][15:0] mem;
        logic [frame_sched_pkg::FIFO_AW-1:0]          wr_ptr;
        logic [frame_sched_pkg::FIFO_AW-1:0]          rd_ptr;
        logic [frame_sched_pkg::FIFO_AW:0]            count;
        logic [15:0]                                  rd_data;
        logic                                         rd_valid;
    } fifo_t;

    fifo_t fifo_r;
    fifo_t fifo_nxt;
    logic  do_wr;
    logic  do_rd;

    assign fp.full     = (fifo_r.count == (frame_sched_pkg::FIFO_AW+1)'(frame_sched_pkg::FIFO_DEPTH));
    assign fp.rd_data  = fifo_r.rd_data;
    assign fp.rd_valid = fifo_r.rd_valid;

    always_comb begin
        fifo_nxt = fifo_r;
        do_wr    = fp.wr_en && !fp.full;
        do_rd    = fp.rd_en && fifo_r.rd_valid;
        if (do_wr) begin
            fifo_nxt.mem[fifo_r.wr_ptr] = fp.wr_data;
            fifo_nxt.wr_ptr             = fifo_r.wr_ptr + (frame_sched_pkg::FIFO_AW)'(1);
        end
        if (do_rd) begin
            fifo_nxt.rd_ptr = fifo_r.rd_ptr + (frame_sched_pkg::FIFO_AW)'(1);
        end
        fifo_nxt.count    = fifo_r.count + (frame_sched_pkg::FIFO_AW+1)'(do_wr)
                            - (frame_sched_pkg::FIFO_AW+1)'(do_rd);
        fifo_nxt.rd_data  = fifo_r.mem[fifo_r.rd_ptr];
        // Hold valid low one cycle after a pop so the new head settles
        fifo_nxt.rd_valid = (fifo_r.count != '0) && !do_rd;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fifo_r <= '0;
        end else if (ce) begin
            fifo_r <= fifo_nxt;
        end
    end
endmodule : push_fifo_mem
`default_nettype wire

/* rtl/combined_serial_frame_scheduler.sv */
// Purpose: Schedules periodic stream frames and host SPI frames on one serial link.
// Assumes: Host control bits come from logic on core_clk; baud_clk is foreign.
// Notes:   Stream frames outrank FIFO frames; a halt waits for idle.
// Notes on behaviour
// - Combined mode interleaves stream and SPI frames.
// - Stop request halts before next transfer.
// - Running status drops only once truly halted.
// - Clearing stop request resumes, queued frames included.
// - Stream-only and SPI-only modes exist.
// - Done flag set; interrupt gated by enable.
`timescale 1ns/10ps
`default_nettype none
module combined_serial_frame_scheduler (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic [1:0]  mode,
    input  wire logic        halt_req,
    input  wire logic        push_valid,
    input  wire logic [15:0] push_data,
    output logic             push_ready,
    input  wire logic [15:0] stream_data,
    input  wire logic        done_clear,
    input  wire logic        done_req_enable,
    output logic             transfer_running,
    output logic             halted,
    output logic             transfer_done_flag,
    output logic             done_irq,
    input  wire logic        baud_clk,
    output logic             sclk,
    output logic             mosi,
    output logic             cs_n,
    output logic             frame_is_spi
);
    typedef struct packed {
        frame_sched_pkg::state_t st;
        logic [1:0]              baud_sync;
        logic                    baud_prev;
        logic [7:0]              period_cnt;
        logic                    stream_due;
        logic [5:0]              tick_cnt;
        logic [15:0]             shift;
        logic                    sclk;
        logic                    cs_n;
        logic                    is_spi;
        logic                    done_flag;
    } sched_t;

    localparam sched_t SCHED_RESET = '{
        st:         frame_sched_pkg::ST_IDLE,
        baud_sync:  2'h0,
        baud_prev:  1'b0,
        period_cnt: 8'h00,
        stream_due: 1'b0,
        tick_cnt:   6'h00,
        shift:      frame_sched_pkg::FRAME_RESET,
        sclk:       1'b0,
        cs_n:       1'b1,
        is_spi:     1'b0,
        done_flag:  1'b0
    };

    // Frame launch shared by the stream and FIFO paths
    function automatic sched_t start_frame(input sched_t      cur,
                                           input logic [15:0] word,
                                           input logic        spi);
        sched_t nxt;
        nxt          = cur;
        nxt.st       = frame_sched_pkg::ST_SHIFT;
        nxt.shift    = word;
        nxt.is_spi   = spi;
        nxt.cs_n     = 1'b0;
        nxt.tick_cnt = 6'h00;
        return nxt;
    endfunction : start_frame

    // Phase counters compare against length less one
    function automatic logic last_tick(input logic [5:0] cnt,
                                       input logic [5:0] len);
        return cnt == len - 6'h01;
    endfunction : last_tick

    function automatic logic [5:0] next_tick(input logic [5:0] cnt);
        return cnt + 6'h01;
    endfunction : next_tick

    sched_t      s_r;
    sched_t      s_nxt;
    logic        baud_tick;
    logic        stream_on;
    logic        spi_on;
    logic        frame_end;

    fifo_port_if fp ();

    push_fifo_mem u_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .ce       (ce),
        .fp       (fp)
    );

    assign fp.wr_en   = push_valid;
    assign fp.wr_data = push_data;
    // Only a full FIFO refuses; a halt does not
    assign push_ready = !fp.full;

    assign transfer_running   = (s_r.st != frame_sched_pkg::ST_HALTED);
    assign halted             = (s_r.st == frame_sched_pkg::ST_HALTED);
    assign transfer_done_flag = s_r.done_flag;
    assign done_irq           = s_r.done_flag && done_req_enable;
    assign sclk               = s_r.sclk;
    assign mosi               = s_r.shift[frame_sched_pkg::FRAME_BITS-1];
    assign cs_n               = s_r.cs_n;
    assign frame_is_spi       = s_r.is_spi;

    // Only the second sync stage feeds the edge detector
    assign baud_tick = s_r.baud_sync[1] && !s_r.baud_prev;
    assign stream_on = (mode != frame_sched_pkg::MODE_SPI_ONLY);
    assign spi_on    = (mode != frame_sched_pkg::MODE_STREAM_ONLY);
    assign frame_end = baud_tick && (s_r.st == frame_sched_pkg::ST_DELAY)
                       && last_tick(s_r.tick_cnt, frame_sched_pkg::DT_TICKS);

    always_comb begin
        s_nxt           = s_r;
        fp.rd_en        = 1'b0;
        s_nxt.baud_sync = {s_r.baud_sync[0], baud_clk};
        s_nxt.baud_prev = s_r.baud_sync[1];

        // Stream period keeps running while halted so cadence is not skewed
        if (!stream_on) begin
            s_nxt.period_cnt = 8'h00;
            s_nxt.stream_due = 1'b0;
        end else if (baud_tick) begin
            if (s_r.period_cnt == frame_sched_pkg::STREAM_PERIOD - 8'h01) begin
                s_nxt.period_cnt = 8'h00;
                s_nxt.stream_due = 1'b1;
            end else begin
                s_nxt.period_cnt = s_r.period_cnt + 8'h01;
            end
        end

        case (s_r.st)
            frame_sched_pkg::ST_IDLE: begin
                if (halt_req) begin
                    s_nxt.st = frame_sched_pkg::ST_HALTED;
                end else if (s_r.stream_due && stream_on) begin
                    s_nxt            = start_frame(s_nxt, stream_data, 1'b0);
                    s_nxt.stream_due = 1'b0;
                end else if (spi_on && fp.rd_valid) begin
                    fp.rd_en = 1'b1;
                    s_nxt    = start_frame(s_nxt, fp.rd_data, 1'b1);
                end
            end
            frame_sched_pkg::ST_SHIFT: begin
                if (baud_tick) begin
                    s_nxt.sclk     = !s_r.sclk;
                    s_nxt.tick_cnt = next_tick(s_r.tick_cnt);
                    // Data moves on the falling edge, sampled on the rising
                    if (s_r.sclk) begin
                        s_nxt.shift = {s_r.shift[14:0], 1'b0};
                    end
                    // Last tick closes the select and parks sclk low
                    if (last_tick(s_r.tick_cnt, frame_sched_pkg::FRAME_TICKS)) begin
                        s_nxt.st       = frame_sched_pkg::ST_DELAY;
                        s_nxt.tick_cnt = 6'h00;
                        s_nxt.cs_n     = 1'b1;
                        s_nxt.sclk     = 1'b0;
                    end
                end
            end
            frame_sched_pkg::ST_DELAY: begin
                if (baud_tick) begin
                    s_nxt.tick_cnt = next_tick(s_r.tick_cnt);
                end
                if (frame_end) begin
                    s_nxt.st = frame_sched_pkg::ST_IDLE;
                end
            end
            frame_sched_pkg::ST_HALTED: begin
                if (!halt_req) begin
                    s_nxt.st = frame_sched_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = frame_sched_pkg::ST_IDLE;
            end
        endcase

        if (done_clear) begin
            s_nxt.done_flag = 1'b0;
        end
        if (frame_end) begin
            s_nxt.done_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_r <= SCHED_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end
endmodule : combined_serial_frame_scheduler
`default_nettype wire

/* tb/sched_asserts.sv */
// Purpose: Port assertions for the frame scheduler.
// Assumes: One core_clk domain, ce held high by the bench.
// Notes:   Frame window allows for baud sync jitter.
`timescale 1ns/10ps
`default_nettype none
module sched_asserts (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       ce,
    input wire logic [1:0] mode,
    input wire logic       halt_req,
    input wire logic       done_clear,
    input wire logic       done_req_enable,
    input wire logic       transfer_running,
    input wire logic       halted,
    input wire logic       transfer_done_flag,
    input wire logic       done_irq,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       frame_is_spi
);
    logic [10:0] low_cnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Cycles with select low; a frame is too long for a delay window
    always_ff @(posedge core_clk) begin
        if (reset) begin
            low_cnt <= 11'h000;
        end else if (ce) begin
            if (cs_n) begin
                low_cnt <= 11'h000;
            end else begin
                low_cnt <= low_cnt + 11'h001;
            end
        end
    end

    a_status_pair: assert property ($fell(transfer_running) |-> halted && $past(cs_n))
        else $error("status dropped mid-frame");
    a_irq_gate: assert property (done_irq == (transfer_done_flag && done_req_enable))
        else $error("irq not gated");
    a_halt_quiet: assert property (halted |-> cs_n)
        else $error("frame while halted");
    a_halt_resume: assert property (halted && !halt_req && ce |=> transfer_running)
        else $error("no resume");
    a_flag_sticky: assert property (transfer_done_flag && !done_clear |=> transfer_done_flag)
        else $error("flag lost");
    a_frame_len: assert property ($rose(cs_n) |-> low_cnt >= 11'h3D4 && low_cnt <= 11'h424)
        else $error("frame length");
    a_frame_bound: assert property (low_cnt <= 11'h424)
        else $error("frame too long");
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("sclk not idle");
    a_spi_mode: assert property (mode == 2'h2 && $fell(cs_n) |-> frame_is_spi)
        else $error("wrong frame kind");
endmodule : sched_asserts
bind combined_serial_frame_scheduler sched_asserts sched_asserts_i (.core_clk, .reset, .ce,
    .mode, .halt_req, .done_clear, .done_req_enable, .transfer_running, .halted,
    .transfer_done_flag, .done_irq, .sclk, .cs_n, .frame_is_spi);
`default_nettype wire

/* tb/link_rx_model.sv */
// Purpose: Serial slave model collecting whole frames.
// Assumes: Bits taken on sclk rise, MSB first.
// Notes:   Partial frames are dropped, not counted.
`timescale 1ns/10ps
`default_nettype none
module link_rx_model (
    input  wire logic  sclk,
    input  wire logic  mosi,
    input  wire logic  cs_n,
    output logic [15:0] word,
    output int          count
);
    logic [15:0] sh = 16'h0000;
    int          nbits = 0;
    initial count = 0;
    always @(posedge sclk) begin
        if (!cs_n) begin
            sh = {sh[14:0], mosi};
            nbits++;
        end
    end
    always @(posedge cs_n) begin
        if (nbits == 16) begin
            word = sh;
            count++;
        end
        nbits = 0;
    end
endmodule : link_rx_model
`default_nettype wire

/* tb/tb_combined_serial_frame_scheduler.sv */
// Purpose: Directed bench for the frame scheduler.
// Assumes: ce held high; baud clock free running at 160 ns.
// Notes:   Frame wait covers a stream period plus a frame.
`timescale 1ns/10ps
`default_nettype none
module tb_combined_serial_frame_scheduler;
    logic        core_clk = 1'h0, reset = 1'h1, ce = 1'h1, baud_clk = 1'h0;
    logic        halt_req = 1'h0, push_valid = 1'h0, done_clear = 1'h0;
    logic        done_req_enable = 1'h0, seen_spi, seen_st;
    logic [1:0]  mode = 2'h0;
    logic [15:0] push_data = 16'h0000, stream_data = 16'h0000, got;
    logic        push_ready, transfer_running, halted, transfer_done_flag, done_irq;
    logic        sclk, mosi, cs_n, frame_is_spi;
    int          n_errors = 0, cmp_count = 0, cycles = 0, rx_count, k;

    always #2.5 core_clk = ~core_clk;
    initial #7 forever #80 baud_clk = ~baud_clk;

    combined_serial_frame_scheduler combined_serial_frame_scheduler_i (.core_clk, .reset,
        .ce, .mode, .halt_req, .push_valid, .push_data, .push_ready, .stream_data,
        .done_clear, .done_req_enable, .transfer_running, .halted, .transfer_done_flag,
        .done_irq, .baud_clk, .sclk, .mosi, .cs_n, .frame_is_spi);
    link_rx_model link_rx_model_i (.sclk, .mosi, .cs_n, .word(got), .count(rx_count));

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic push(input logic [15:0] d);
        push_valid = 1'h1;
        push_data = d;
        tick(1);
        push_valid = 1'h0;
        tick(1);
    endtask : push
    // Bounded wait for the next whole frame at the slave
    task automatic frame();
        int c = rx_count;
        int k = 0;
        while (rx_count == c && k < 4000) begin
            tick(1);
            k++;
        end
        chk("frame_seen", 16'(rx_count != c), 16'h0001);
    endtask : frame
    task automatic wrap_up();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        tick(5);
        reset = 1'h0;
        mode = 2'h2;
        chk("running", transfer_running, 1'h1);
        halt_req = 1'h1;
        tick(3);
        chk("halted", halted, 1'h1);
        for (int i = 0; i < 8; i++) push(16'hC0D0 + 16'(i));
        chk("ready", push_ready, 1'h0);
        tick(300);
        chk("cs_n", cs_n, 1'h1);
        halt_req = 1'h0;
        done_req_enable = 1'h1;
        for (int i = 0; i < 8; i++) begin
            frame();
            chk("spi_word", got, 16'hC0D0 + 16'(i));
            chk("kind", frame_is_spi, 1'h1);
        end
        tick(150);
        chk("irq", done_irq, 1'h1);
        done_clear = 1'h1;
        tick(1);
        done_clear = 1'h0;
        tick(1);
        chk("flag", transfer_done_flag, 1'h0);
        $display("test spi_fill done");
        stream_data = 16'hA5C3;
        done_req_enable = 1'h0;
        mode = 2'h1;
        frame();
        chk("st_word", got, 16'hA5C3);
        chk("kind", frame_is_spi, 1'h0);
        tick(150);
        chk("flag", transfer_done_flag, 1'h1);
        chk("irq", done_irq, 1'h0);
        $display("test stream_only done");
        mode = 2'h0;
        stream_data = 16'h5A3C;
        halt_req = 1'h1;
        // fixed wait, 32 core cycles per baud clock, then one look
        tick(frame_sched_pkg::HALT_WAIT_BAUD * 32 + 40);
        chk("halted", halted, 1'h1);
        // push only while halted, never late in the delay phase
        push(16'h1234);
        halt_req = 1'h0;
        seen_spi = 1'h0;
        seen_st = 1'h0;
        repeat (3) begin
            frame();
            if (got === 16'h1234 && frame_is_spi === 1'h1) seen_spi = 1'h1;
            if (got === 16'h5A3C && frame_is_spi === 1'h0) seen_st = 1'h1;
        end
        chk("spi_seen", seen_spi, 1'h1);
        chk("st_seen", seen_st, 1'h1);
        $display("test combined done");
        // halt mid-frame, serve the done request, push, release
        k = 0;
        while (cs_n !== 1'h0 && k < 4000) begin
            tick(1);
            k++;
        end
        halt_req = 1'h1;
        done_clear = 1'h1;
        tick(1);
        done_clear = 1'h0;
        done_req_enable = 1'h1;
        chk("busy", transfer_running, 1'h1);
        chk("busy_flag", transfer_done_flag, 1'h0);
        k = 0;
        while (done_irq !== 1'h1 && k < 2000) begin
            tick(1);
            k++;
        end
        chk("isr_irq", done_irq, 1'h1);
        done_clear = 1'h1;
        done_req_enable = 1'h0;
        tick(1);
        done_clear = 1'h0;
        chk("isr_halted", halted, 1'h1);
        chk("isr_flag", transfer_done_flag, 1'h0);
        push(16'h4321);
        halt_req = 1'h0;
        frame();
        chk("isr_word", got, 16'h4321);
        $display("test isr done");
        wrap_up();
    end
endmodule : tb_combined_serial_frame_scheduler
`default_nettype wire
